//--- logic/beacon_pkg.sv
package beacon_pkg;
  // Stored word length.
  localparam int WORD_BITS = 154;
  // Bit counter width.
  localparam int BIT_IDX_W = 8;
  // Core clock rate in Hz.
  localparam int CLK_HZ = 10000000;
  // Nominal bit rate in Hz.
  localparam int BIT_RATE_HZ = 70000;
  // Cycles per half bit, rounded down.
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
  // Half-bit counter width.
  localparam int HALF_W = 7;
  // Nominal sleep time in ms.
  localparam int SLEEP_MS = 100;
  // Nominal sleep time in cycles.
  localparam int SLEEP_CYC = CLK_HZ / 1000 * SLEEP_MS;
  // Sleep counter width.
  localparam int SLEEP_W = 24;
  // Sleep seed width and its reset value.
  localparam int SEED_W = 16;
  localparam logic [SEED_W-1:0] SEED_RST = 16'hace1;
  // Sequencer states.
  typedef enum logic [1:0] {ST_SEND, ST_DRAIN, ST_SLEEP} seq_state_t;
endpackage

//--- logic/bit_link_if.sv
`timescale 1ns/1ps
// Carries data bits from the sequencer to the encoder buffer.
interface bit_link_if;
  logic valid;  // A bit is offered.
  logic ready;  // The buffer can take a bit.
  logic data;   // The offered bit.
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

//--- logic/bit_buffer.sv
`timescale 1ns/1ps
// Two-entry buffer of single data bits with valid and ready on both sides.
module bit_buffer (
  input  wire logic clk,
  input  wire logic rst,
  bit_link_if.dst   in_link,
  output logic      out_valid,
  input  wire logic out_ready,
  output logic      out_data
);
  logic [1:0] mem;    // Storage slots.
  logic       wr_ptr; // Write slot.
  logic       rd_ptr; // Read slot.
  logic [1:0] count;  // Entries held.
  logic       push;   // Word taken in.
  logic       pop;    // Word handed out.

  assign in_link.ready = (count != 2'h2);
  assign out_valid     = (count != 2'h0);
  assign out_data      = mem[rd_ptr];
  assign push          = in_link.valid && in_link.ready;
  assign pop           = out_valid && out_ready;

  // Stores an incoming bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem    <= 2'h0;
      wr_ptr <= 1'b0;
    end else if (push) begin
      mem[wr_ptr] <= in_link.data;
      wr_ptr      <= ~wr_ptr;
    end
  end

  // Advances the read slot.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= 1'b0;
    end else if (pop) begin
      rd_ptr <= ~rd_ptr;
    end
  end

  // Tracks the fill level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- logic/tag_beacon.sv
`timescale 1ns/1ps
module tag_beacon
  import beacon_pkg::*;
#(
  parameter int SLEEP_CYCLES = beacon_pkg::SLEEP_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [beacon_pkg::WORD_BITS-1:0] stored_word,
  input  wire logic [beacon_pkg::SEED_W-1:0]    tag_trim,
  output logic                                  mod_switch,
  output logic                                  frame_active
);
  import beacon_pkg::*;

  bit_link_if link ();              // Sequencer to buffer path.
  seq_state_t           state;      // Sequencer state.
  logic [BIT_IDX_W-1:0] bit_idx;    // Next bit to offer.
  logic [SLEEP_W-1:0]   sleep_cnt;  // Sleep countdown.
  logic [SEED_W-1:0]    lfsr;       // Per-tag spread generator.
  logic [WORD_BITS-1:0] word_q;     // Word latched for this frame.
  logic                 enc_valid;  // Buffer offers a bit.
  logic                 enc_data;   // Bit at the buffer head.
  logic                 enc_take;   // Encoder takes the head bit.
  logic                 busy;       // Encoder is sending a bit.
  logic                 phase;      // Low in first half of a bit.
  logic                 cur_bit;    // Bit being sent.
  logic [HALF_W-1:0]    half_cnt;   // Half-bit timer.
  logic                 half_done;  // End of a half bit.
  logic [SLEEP_W-1:0]   spread;     // Extra sleep for this wake-up.

  // Product width for scaling the spread to the nominal sleep.
  localparam int PROD_W  = SLEEP_W + SEED_W;
  // Cycles from the first sampled half-bit level to the mid-bit edge.
  localparam int MID_DLY = HALF_BIT_CYC;

  logic [PROD_W-1:0]    spread_prod; // Generator value times nominal sleep.

  // Offer bits in fixed order while sending; the word input is read only.
  assign link.valid = (state == ST_SEND);
  assign link.data  = word_q[WORD_BITS-1-int'(bit_idx)];

  bit_buffer u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_link   (link),
    .out_valid (enc_valid),
    .out_ready (enc_take),
    .out_data  (enc_data)
  );

  assign half_done = busy && (half_cnt == HALF_W'(HALF_BIT_CYC - 1));
  assign enc_take  = enc_valid && (!busy || (half_done && phase));
  // The spread spans zero to one nominal sleep, so a tag sleeps from half
  // to one and a half times the nominal time; tags with other trims wake in
  // other slots and seldom talk over each other.
  assign spread_prod = PROD_W'(SLEEP_CYCLES) * PROD_W'(lfsr);
  assign spread      = spread_prod[PROD_W-1:SEED_W];

  // Sequencer: send, let encoder drain, sleep, repeat.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Power-up enters sleep with an empty timer: the next edge starts the
      // first frame and latches the stored word on the way.
      state <= ST_SLEEP;
    end else begin
      unique case (state)
        ST_SEND: begin
          if (link.ready && bit_idx == BIT_IDX_W'(WORD_BITS - 1)) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!enc_valid && !busy) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sleep_cnt == '0) begin
            state <= ST_SEND;
          end
        end
      endcase
    end
  end

  // Bit index restarts at the first bit on every frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_idx <= '0;
    end else if (state != ST_SEND) begin
      bit_idx <= '0;
    end else if (link.ready) begin
      bit_idx <= bit_idx + 1'b1;
    end
  end

  // The word is captured whenever no frame is on air, so every frame,
  // the first after power-up included, sends one consistent stored word.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_q <= '0;
    end else if (state != ST_SEND) begin
      word_q <= stored_word;
    end
  end

  // Sleep timer loads half the nominal time plus the spread at frame end.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_cnt <= '0;
    end else if (state == ST_DRAIN) begin
      sleep_cnt <= SLEEP_W'(SLEEP_CYCLES / 2) + spread;
    end else if (sleep_cnt != '0) begin
      sleep_cnt <= sleep_cnt - 1'b1;
    end
  end

  // The spread generator mixes in the tag trim so tags differ.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr <= SEED_RST;
    end else begin
      lfsr <= {lfsr[SEED_W-2:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]}
              ^ tag_trim;
    end
  end

  // Encoder bit framing: two half bits per data bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy     <= 1'b0;
      phase    <= 1'b0;
      cur_bit  <= 1'b0;
      half_cnt <= '0;
    end else if (enc_take) begin
      busy     <= 1'b1;
      phase    <= 1'b0;
      cur_bit  <= enc_data;
      half_cnt <= '0;
    end else if (half_done) begin
      busy     <= !phase ? 1'b1 : 1'b0;
      phase    <= ~phase;
      half_cnt <= '0;
    end else if (busy) begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // Switch follows the Manchester level; off whenever no bit is sent.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_switch <= 1'b0;
    end else if (enc_take) begin
      // First half carries the bit value itself.
      mod_switch <= enc_data;
    end else if (half_done && !phase) begin
      // Mid-bit edge: a one falls, a zero rises.
      mod_switch <= ~cur_bit;
    end else if (!busy || half_done) begin
      // No bit follows: release the switch at once, so the frame ends
      // without a stray pulse and the sleep stays tuned.
      mod_switch <= 1'b0;
    end
  end

  // Flags a frame in progress.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= (state != ST_SLEEP);
    end
  end

  // Named steps of a Manchester bit.
  sequence s_first_half_one;
    enc_take && enc_data;
  endsequence

  sequence s_first_half_zero;
    enc_take && !enc_data;
  endsequence

  // The last half of a bit ends and no new bit is taken.
  sequence s_bit_end_idle;
    half_done && phase && !enc_take;
  endsequence

  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SLEEP) |=> !mod_switch)
    else $error("Switch active during sleep.");

  AST_ONE_FALLS: assert property (@(posedge clk) disable iff (rst)
    s_first_half_one |=> mod_switch ##MID_DLY !mod_switch)
    else $error("One bit lacks falling mid edge.");

  AST_ZERO_RISES: assert property (@(posedge clk) disable iff (rst)
    s_first_half_zero |=> !mod_switch ##MID_DLY mod_switch)
    else $error("Zero bit lacks rising mid edge.");

  AST_RESTART: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SLEEP && sleep_cnt == '0) |=> (state == ST_SEND && bit_idx == '0))
    else $error("Frame did not restart at first bit.");

  AST_SEND_ENDS: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SEND && link.ready && bit_idx == BIT_IDX_W'(WORD_BITS - 1))
      |=> state == ST_DRAIN)
    else $error("Frame did not end after last bit.");

  AST_DRAIN_SLEEP: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DRAIN && !enc_valid && !busy) |=> state == ST_SLEEP)
    else $error("Sleep not entered after frame.");

  AST_SLEEP_LOAD: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DRAIN) |=> (sleep_cnt >= SLEEP_W'(SLEEP_CYCLES / 2)
      && sleep_cnt <= SLEEP_W'(SLEEP_CYCLES / 2 + SLEEP_CYCLES)))
    else $error("Sleep timer loaded out of range.");

  AST_IDLE_LOW: assert property (@(posedge clk) disable iff (rst)
    (!busy && !enc_valid) |=> !mod_switch)
    else $error("Switch active with no bit.");

  AST_BIT_END_LOW: assert property (@(posedge clk) disable iff (rst)
    s_bit_end_idle |=> !mod_switch)
    else $error("Switch active after last half bit.");
endmodule

//--- bench/reader_model.sv
`timescale 1ns/1ps
// Reader that recovers bits from the tag's cloaking pattern.
module reader_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic mod_switch,
  input  wire logic frame_active,
  output logic      bit_strobe,
  output logic      bit_val
);
  logic       last_lvl;  // Switch level one cycle earlier.
  logic [7:0] gate;      // Edges are ignored while this is non-zero.
  // A mid-bit edge gives one bit: a fall is a one, a rise a zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_lvl <= 1'b0;
      gate <= 8'h24;
      bit_strobe <= 1'b0;
      bit_val <= 1'b0;
    end else begin
      last_lvl <= mod_switch;
      bit_strobe <= 1'b0;
      if (!frame_active) begin
        // An early edge of a frame is a bit start, not a mid-bit edge.
        gate <= 8'h24;
      end else if (gate != 8'h00) begin
        gate <= gate - 8'h01;
      end else if (mod_switch != last_lvl) begin
        bit_strobe <= 1'b1;
        bit_val <= !mod_switch;
        gate <= 8'h6b;
      end
    end
  end
endmodule

//--- bench/test_tag_beacon.sv
`timescale 1ns/1ps
// Runs a cut frame, a full frame, a sleep and a second frame.
module test_tag_beacon;
  import beacon_pkg::*;
  localparam int SLEEP_CYCLES = 200;  // Short sleep keeps the run brief.
  logic                 clk;           // Core clock.
  logic                 rst;           // Power-up reset.
  logic [WORD_BITS-1:0] stored_word;   // Payload offered to the tag.
  logic [SEED_W-1:0]    tag_trim;      // Per-tag spread value.
  logic                 mod_switch;    // Cloaking switch.
  logic                 frame_active;  // High while a frame is on air.
  logic                 bit_strobe;    // The reader recovered a bit.
  logic                 bit_val;       // The recovered bit.
  logic                 prev_fa;       // Frame flag one cycle earlier.
  logic                 in_sleep;      // A sleep between frames runs.
  logic [159:0]         w;             // Random word source.
  logic                 exp_q[$];      // Expected bits, oldest first.
  int                   error_cnt;
  int                   checked;
  int                   seed;
  int                   nbits;
  int                   frames;
  int                   sleep_len;
  int                   quiet_bad;
  int                   last_t;
  int                   cyc;

  tag_beacon #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_tag_beacon (.clk(clk), .rst(rst),
    .stored_word(stored_word), .tag_trim(tag_trim), .mod_switch(mod_switch),
    .frame_active(frame_active));
  reader_model i_reader_model (.clk(clk), .rst(rst), .mod_switch(mod_switch),
    .frame_active(frame_active), .bit_strobe(bit_strobe), .bit_val(bit_val));

  // The clock toggles every half period of 50 ns.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("counts: %0d checked, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, cut the first frame, reset again, then let frames run.
  initial begin
    seed = 32'hc08b;
    rst = 1'b1;
    stored_word = '0;
    tag_trim = '0;
    error_cnt = 0;
    checked = 0;
    frames = 0;
    cyc = 0;
    w = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    // Every frame, the first after power-up too, carries the stored word.
    for (int i = WORD_BITS - 1; i >= 0; i--) exp_q.push_back(w[i]);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    stored_word <= w[WORD_BITS-1:0];
    tag_trim <= w[SEED_W-1:0] ^ 16'h5a3c;
    repeat (5000) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    $display("test cut frame done");
    exp_q.delete();
    // Two whole frames follow the second power-up, in the same order.
    for (int n = 0; n < 2; n++) begin
      for (int i = WORD_BITS - 1; i >= 0; i--) exp_q.push_back(w[i]);
    end
    repeat (4) @(posedge clk);
    check("quiet in reset", {30'h0, frame_active, mod_switch}, 0);
    rst <= 1'b0;
    for (int k = 0; k < 16 && !frame_active; k++) @(posedge clk);
    check("start after reset", frame_active, 1);
    $display("test restart done");
    wait (frames == 2);
    check("bits left", exp_q.size(), 0);
    wrap_up();
  end

  // Watches the reader's bits, frame ends and sleep intervals.
  always @(posedge clk) begin
    cyc++;
    if (rst) begin
      nbits = 0;
      in_sleep = 1'b0;
    end else begin
      if (bit_strobe) begin
        if (exp_q.size() == 0) check("surplus bit", 1, 0);
        else check("payload bit", bit_val, exp_q.pop_front());
        if (nbits > 0) check("bit period", cyc - last_t, 2 * HALF_BIT_CYC);
        last_t = cyc;
        nbits++;
      end
      if (prev_fa && !frame_active) begin
        check("frame bits", nbits, WORD_BITS);
        frames++;
        $display("test frame %0d done", frames);
        nbits = 0;
        sleep_len = 0;
        quiet_bad = 0;
        in_sleep = 1'b1;
      end else if (in_sleep && !frame_active) begin
        sleep_len++;
        if (mod_switch !== 1'b0) quiet_bad++;
      end else if (in_sleep) begin
        check("sleep quiet", quiet_bad, 0);
        check("sleep span", sleep_len >= SLEEP_CYCLES / 2
          && sleep_len <= SLEEP_CYCLES / 2 + SLEEP_CYCLES, 1);
        in_sleep = 1'b0;
      end
    end
    prev_fa = frame_active;
  end

  // Cuts a hang short after more than the longest expected run.
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
